// ### hdl/wdtc_consts.svh
// Offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDTC_CONSTS_SVH
`define WDTC_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define WDTC_CTRL_OFS 8'h00
`define WDTC_RELOAD_OFS 8'h04
`define WDTC_FEED1_OFS 8'h08
`define WDTC_FEED2_OFS 8'h0C
`define WDTC_CLKCFG_OFS 8'h10
`define WDTC_STATUS_OFS 8'h14

// ==========================================================================
// Control register fields
`define WDTC_CTRL_OSC_BIT 0
`define WDTC_CTRL_FLAG_BIT 1
`define WDTC_CTRL_RUN_BIT 2
`define WDTC_CTRL_PRE_LSB 5
`define WDTC_CTRL_PRE_MSB 7

// Clock configuration fields
`define WDTC_CFG_RESET_FUNCTION_ENABLE_BIT 0
`define WDTC_CFG_XTAL_BIT 4
`define WDTC_CFG_IRQEN_BIT 6

// ==========================================================================
// Reset values
`define WDTC_PRE_RST 3'h7
`define WDTC_RUN_RST 1'b1
`define WDTC_OSC_RST 1'b1
`define WDTC_RELOAD_RST 8'hFF

// Feed sequence bytes
`define WDTC_FEED1_VAL 8'hA5
`define WDTC_FEED2_VAL 8'h5A

// ==========================================================================
// Timing: base prescale exponent and source rates
`define WDTC_PRE_BASE 5
`define WDTC_CLK_HZ 25000000
`define WDTC_OSC_HZ 400000
`define WDTC_OSC_DIV (`WDTC_CLK_HZ / `WDTC_OSC_HZ)
`define WDTC_SW_SYNC 2'h1

`endif

// ### hdl/wdtc_pkg.sv
// Types shared by the watchdog core and its clock switch
package wdtc_pkg;
    typedef enum logic [1:0] {
        SRC_PCLK = 2'b00,
        SRC_OSC = 2'b01,
        SRC_XTAL = 2'b10
    } wdtc_src_e;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_OLD = 2'b01,
        SW_NEW = 2'b10
    } wdtc_sw_e;

    typedef enum logic {
        FEED_IDLE = 1'b0,
        FEED_ARMED = 1'b1
    } wdtc_feed_e;
endpackage : wdtc_pkg

// ### hdl/wdtc_clk_switch.sv
// Glitch-free watchdog clock source switch working on tick enables
`timescale 1ns/10ps
`include "wdtc_consts.svh"
module wdtc_clk_switch (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pclk_tick,
    input wire logic osc_tick,
    input wire logic xtal_tick,
    input wire logic load,
    input wire logic sel_osc,
    input wire logic sel_xtal,
    output logic wd_tick,
    output wdtc_pkg::wdtc_src_e active,
    output logic busy
);
    typedef struct packed {
        wdtc_pkg::wdtc_sw_e st;
        logic [1:0] cnt;
        wdtc_pkg::wdtc_src_e act;
        wdtc_pkg::wdtc_src_e tgt;
        logic tick;
    } wdtc_sw_s;

    wdtc_sw_s q;
    wdtc_sw_s d;
    wdtc_pkg::wdtc_src_e req;

    function automatic logic src_tick(input wdtc_pkg::wdtc_src_e s,
                                      input logic p, input logic o,
                                      input logic x);
        unique case (s)
            wdtc_pkg::SRC_PCLK: src_tick = p;
            wdtc_pkg::SRC_OSC: src_tick = o;
            wdtc_pkg::SRC_XTAL: src_tick = x;
            default: src_tick = 1'b0;
        endcase
    endfunction : src_tick

    always_comb begin
        req = sel_xtal ? wdtc_pkg::SRC_XTAL :
              (sel_osc ? wdtc_pkg::SRC_OSC : wdtc_pkg::SRC_PCLK);
        d = q;
        d.tick = 1'b0;
        unique case (q.st)
            wdtc_pkg::SW_IDLE: begin
                d.tick = src_tick(q.act, pclk_tick, osc_tick, xtal_tick);
                if (load && req != q.act) begin
                    d.tgt = req;
                    d.st = wdtc_pkg::SW_OLD;
                    d.cnt = 2'h0;
                end
            end
            wdtc_pkg::SW_OLD: begin
                // Old source keeps feeding the prescaler while it is released
                d.tick = src_tick(q.act, pclk_tick, osc_tick, xtal_tick);
                if (load) begin
                    d.tgt = req;
                end
                // A stopped old clock leaves the switch pending here
                if (src_tick(q.act, pclk_tick, osc_tick, xtal_tick)) begin
                    if (q.cnt == `WDTC_SW_SYNC) begin
                        d.st = wdtc_pkg::SW_NEW;
                        d.cnt = 2'h0;
                    end else begin
                        d.cnt = q.cnt + 2'h1;
                    end
                end
            end
            wdtc_pkg::SW_NEW: begin
                if (load) begin
                    d.tgt = req;
                end
                if (src_tick(q.tgt, pclk_tick, osc_tick, xtal_tick)) begin
                    if (q.cnt == `WDTC_SW_SYNC) begin
                        d.act = q.tgt;
                        d.st = wdtc_pkg::SW_IDLE;
                    end else begin
                        d.cnt = q.cnt + 2'h1;
                    end
                end
            end
            default: begin
                d.st = wdtc_pkg::SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '{st: wdtc_pkg::SW_IDLE, cnt: 2'h0, act: wdtc_pkg::SRC_OSC,
                   tgt: wdtc_pkg::SRC_OSC, tick: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign wd_tick = q.tick;
    assign active = q.act;
    assign busy = (q.st != wdtc_pkg::SW_IDLE);

    // ======================================================================
    // Checks
    property p_switch_deferred;
        @(posedge ref_clk) disable iff (sys_rst)
        (load && !busy && req != active) |=> busy && active == $past(active);
    endproperty
    a_switch_deferred: assert property (p_switch_deferred)
        else $error("source changed without synchronisation");

    property p_new_after_two;
        @(posedge ref_clk) disable iff (sys_rst)
        (active != $past(active)) |->
            $past(q.st == wdtc_pkg::SW_NEW && q.cnt == `WDTC_SW_SYNC);
    endproperty
    a_new_after_two: assert property (p_new_after_two)
        else $error("new source selected too early");
endmodule : wdtc_clk_switch

// ### hdl/wdtc_core.sv
// Watchdog timer core: clock choice, prescaler, down counter, feed, bus
//
// Summary of operation
// - Dedicated 400 kHz oscillator tick source
// - Crystal wins, else oscillator bit, else peripheral
// - Clock selection applies only after good feed
// - Two old then two new ticks on switch
// - Prescaler restarts at feed during a switch
// - Stopped CPU clock leaves switch pending
// - Timer mode: control shadowed after one tick
// - Underflow sets flag, interrupt when enabled
// - Timer mode flag cleared by writing zero
// - Timer mode underflow reloads and keeps counting
// - Timer mode: feed reloads, bad feed ignored
// - Oscillator selected: counting continues in power-down
// - Peripheral clock selected: power-down stops counting
// - Underflow during power-down wakes device
// - Timeout spans 33 to 1048577 ticks
// - Timeout is 2^(5+tap)*(reload+1)+1
// - Feed is A5 then 5A, no write between
// - Reset enable low means timer mode only
`timescale 1ns/10ps
`include "wdtc_consts.svh"
module wdtc_core (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic power_down,
    input wire logic xtal_tick,
    output logic wdt_irq,
    output logic wake_req,
    output logic chip_rst_req
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        wdtc_pkg::wdtc_feed_e feed;
        logic [2:0] pre_sw;
        logic run_sw;
        logic osc_sw;
        logic xtal_sw;
        logic reset_function_enable;
        logic irq_en;
        logic [2:0] pre_sh;
        logic run_sh;
        logic [7:0] reload;
        logic [7:0] dcnt;
        logic [11:0] pcnt;
        logic tail;
        logic flag;
        logic pclk_div;
        logic [5:0] osc_div;
        logic pclk_tick;
        logic osc_tick;
        logic sel_load;
        logic irq;
        logic wake;
        logic rst_req;
    } wdtc_core_s;

    wdtc_core_s q;
    wdtc_core_s d;

    logic wd_tick;
    wdtc_pkg::wdtc_src_e active;
    logic sw_busy;

    logic wr;
    logic rd;
    logic lane0;
    logic [7:0] wbyte;
    logic feed_ok;
    logic feed_bad;
    logic uf;
    logic clr_flag;
    logic [2:0] pre_use;

    // Prescaler top for a tap: 2^(5+tap) ticks per down-count step
    function automatic logic [11:0] pre_top(input logic [2:0] tap);
        pre_top = 12'((32'h1 << (`WDTC_PRE_BASE + 32'(tap))) - 32'h1);
    endfunction : pre_top

    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    wdtc_clk_switch u_switch (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pclk_tick(q.pclk_tick),
        .osc_tick(q.osc_tick),
        .xtal_tick(xtal_tick),
        .load(q.sel_load),
        .sel_osc(q.osc_sw),
        .sel_xtal(q.xtal_sw),
        .wd_tick(wd_tick),
        .active(active),
        .busy(sw_busy)
    );

    always_comb begin
        d = q;
        // ==================================================================
        // Bus decode: one-cycle registered ack, writes land with the ack
        wr = wb_cyc_i && wb_stb_i && !q.ack && wb_we_i;
        rd = wb_cyc_i && wb_stb_i && !q.ack && !wb_we_i;
        lane0 = wb_sel_i[0];
        wbyte = wb_dat_i[7:0];
        d.ack = wb_cyc_i && wb_stb_i && !q.ack;

        // ==================================================================
        // Tick sources; peripheral clock is half the CPU clock
        d.pclk_div = power_down ? q.pclk_div : !q.pclk_div;
        d.pclk_tick = !power_down && q.pclk_div;
        // Oscillator sleeps with the chip unless it drives the watchdog
        d.osc_tick = 1'b0;
        if (!power_down || active == wdtc_pkg::SRC_OSC) begin
            if (q.osc_div == 6'(`WDTC_OSC_DIV - 1)) begin
                d.osc_div = 6'h00;
                d.osc_tick = 1'b1;
            end else begin
                d.osc_div = q.osc_div + 6'h01;
            end
        end

        // ==================================================================
        // Feed sequence
        feed_ok = 1'b0;
        feed_bad = 1'b0;
        d.sel_load = 1'b0;
        unique case (q.feed)
            wdtc_pkg::FEED_IDLE: begin
                if (wr && hit(wb_adr_i, `WDTC_FEED1_OFS)) begin
                    if (lane0 && wbyte == `WDTC_FEED1_VAL) begin
                        d.feed = wdtc_pkg::FEED_ARMED;
                    end else begin
                        feed_bad = 1'b1;
                    end
                end else if (wr && hit(wb_adr_i, `WDTC_FEED2_OFS)) begin
                    feed_bad = 1'b1;
                end
            end
            wdtc_pkg::FEED_ARMED: begin
                if (wr) begin
                    d.feed = wdtc_pkg::FEED_IDLE;
                    if (hit(wb_adr_i, `WDTC_FEED2_OFS) && lane0 &&
                        wbyte == `WDTC_FEED2_VAL) begin
                        feed_ok = 1'b1;
                    end else begin
                        feed_bad = 1'b1;
                    end
                end
            end
        endcase

        // ==================================================================
        // Register writes
        clr_flag = 1'b0;
        if (wr && lane0) begin
            if (hit(wb_adr_i, `WDTC_CTRL_OFS)) begin
                d.pre_sw = wbyte[`WDTC_CTRL_PRE_MSB:`WDTC_CTRL_PRE_LSB];
                d.run_sw = wbyte[`WDTC_CTRL_RUN_BIT];
                d.osc_sw = wbyte[`WDTC_CTRL_OSC_BIT];
                clr_flag = !wbyte[`WDTC_CTRL_FLAG_BIT];
            end
            if (hit(wb_adr_i, `WDTC_RELOAD_OFS)) begin
                d.reload = wbyte;
            end
            if (hit(wb_adr_i, `WDTC_CLKCFG_OFS)) begin
                d.xtal_sw = wbyte[`WDTC_CFG_XTAL_BIT];
                d.reset_function_enable = wbyte[`WDTC_CFG_RESET_FUNCTION_ENABLE_BIT];
                d.irq_en = wbyte[`WDTC_CFG_IRQEN_BIT];
            end
        end

        // ==================================================================
        // Shadow control: timer mode follows after one watchdog tick
        if (!q.reset_function_enable && wd_tick) begin
            d.pre_sh = q.pre_sw;
            d.run_sh = q.run_sw;
        end
        pre_use = q.reset_function_enable ? q.pre_sw : q.pre_sh;

        // ==================================================================
        // Counter: 2^(5+tap) ticks per step, reload+1 steps, one tail tick
        uf = wd_tick && q.run_sh && q.dcnt == 8'h00 && q.pcnt == 12'h000 &&
             q.tail;
        if (feed_ok) begin
            // Prescaler restarts now even while the source is changing
            d.dcnt = q.reload;
            d.pcnt = pre_top(pre_use);
            d.tail = 1'b0;
            d.sel_load = 1'b1;
            if (q.reset_function_enable) begin
                d.pre_sh = q.pre_sw;
                d.run_sh = q.run_sw;
            end
        end else if (uf) begin
            d.dcnt = q.reload;
            d.pcnt = pre_top(q.pre_sh);
            d.tail = 1'b0;
        end else if (wd_tick && q.run_sh) begin
            if (q.pcnt != 12'h000) begin
                d.pcnt = q.pcnt - 12'h001;
            end else if (q.dcnt != 8'h00) begin
                d.dcnt = q.dcnt - 8'h01;
                d.pcnt = pre_top(q.pre_sh);
            end else begin
                d.tail = 1'b1;
            end
        end

        // Underflow outranks a clearing write in the same cycle
        d.flag = (q.flag && !clr_flag && !(feed_ok && q.reset_function_enable)) || uf;
        d.irq = d.flag && q.irq_en;
        d.wake = uf && power_down;
        // Watchdog mode alone may reset the chip
        d.rst_req = q.reset_function_enable && (uf || feed_bad);

        // ==================================================================
        // Read data
        d.rdat = 32'h0000_0000;
        if (rd) begin
            if (hit(wb_adr_i, `WDTC_CTRL_OFS)) begin
                d.rdat[`WDTC_CTRL_PRE_MSB:`WDTC_CTRL_PRE_LSB] = q.pre_sw;
                d.rdat[`WDTC_CTRL_RUN_BIT] = q.run_sw;
                d.rdat[`WDTC_CTRL_FLAG_BIT] = q.flag;
                d.rdat[`WDTC_CTRL_OSC_BIT] = q.osc_sw;
            end else if (hit(wb_adr_i, `WDTC_RELOAD_OFS)) begin
                d.rdat[7:0] = q.reload;
            end else if (hit(wb_adr_i, `WDTC_CLKCFG_OFS)) begin
                d.rdat[`WDTC_CFG_XTAL_BIT] = q.xtal_sw;
                d.rdat[`WDTC_CFG_RESET_FUNCTION_ENABLE_BIT] = q.reset_function_enable;
                d.rdat[`WDTC_CFG_IRQEN_BIT] = q.irq_en;
            end else if (hit(wb_adr_i, `WDTC_STATUS_OFS)) begin
                d.rdat[7:0] = q.dcnt;
                d.rdat[8] = sw_busy;
                d.rdat[10:9] = active;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.pre_sw <= `WDTC_PRE_RST;
            q.run_sw <= `WDTC_RUN_RST;
            q.osc_sw <= `WDTC_OSC_RST;
            q.pre_sh <= `WDTC_PRE_RST;
            q.run_sh <= `WDTC_RUN_RST;
            q.reload <= `WDTC_RELOAD_RST;
            q.dcnt <= `WDTC_RELOAD_RST;
            q.pcnt <= 12'hFFF;
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign wdt_irq = q.irq;
    assign wake_req = q.wake;
    assign chip_rst_req = q.rst_req;

    // ======================================================================
    // Checks
    property p_flag_set;
        @(posedge ref_clk) disable iff (sys_rst)
        uf |=> q.flag ##1 (q.irq == q.irq_en || $past(q.irq_en) != q.irq_en);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("underflow did not raise flag");

    property p_flag_sticky;
        @(posedge ref_clk) disable iff (sys_rst)
        (q.flag && !q.reset_function_enable && !clr_flag) |=> q.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without a clearing write");

    property p_uf_reload;
        @(posedge ref_clk) disable iff (sys_rst)
        (uf && !feed_ok) |=> q.dcnt == $past(q.reload) && !q.tail;
    endproperty
    a_uf_reload: assert property (p_uf_reload)
        else $error("counter not reloaded on underflow");

    property p_feed_load;
        @(posedge ref_clk) disable iff (sys_rst)
        feed_ok |=> q.dcnt == $past(q.reload) && !q.tail &&
            q.pcnt == pre_top($past(pre_use));
    endproperty
    a_feed_load: assert property (p_feed_load)
        else $error("feed did not load counter");

    property p_timer_no_reset;
        @(posedge ref_clk) disable iff (sys_rst)
        !q.reset_function_enable |=> !chip_rst_req;
    endproperty
    a_timer_no_reset: assert property (p_timer_no_reset)
        else $error("reset requested in timer mode");

    property p_wake;
        @(posedge ref_clk) disable iff (sys_rst)
        (uf && power_down) |=> wake_req ##1 !wake_req;
    endproperty
    a_wake: assert property (p_wake)
        else $error("underflow in power-down did not wake");

    property p_shadow;
        @(posedge ref_clk) disable iff (sys_rst)
        (wd_tick && !q.reset_function_enable) |=> q.pre_sh == $past(q.pre_sw);
    endproperty
    a_shadow: assert property (p_shadow)
        else $error("shadow control not updated after tick");

    property p_pd_stop;
        @(posedge ref_clk) disable iff (sys_rst)
        power_down [*2] |-> !q.pclk_tick;
    endproperty
    a_pd_stop: assert property (p_pd_stop)
        else $error("peripheral tick ran in power-down");

    property p_reload_kept;
        @(posedge ref_clk) disable iff (sys_rst)
        (uf && !(wr && hit(wb_adr_i, `WDTC_RELOAD_OFS))) |=>
            $stable(q.reload);
    endproperty
    a_reload_kept: assert property (p_reload_kept)
        else $error("reload register changed by underflow");
endmodule : wdtc_core

// ### testbench/wdtc_core_tb.sv
// Self-checking bench for the watchdog timer core
`timescale 1ns/10ps
`include "wdtc_consts.svh"
module wdtc_core_tb;
    // ======================================================================
    // Stimulus signals and bookkeeping
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic power_down = 1'b0;
    logic xtal_tick = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wdt_irq;
    logic wake_req;
    logic chip_rst_req;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int irq_rises = 0;
    int wakes = 0;
    int rsts = 0;
    int rise_t = 0;
    int t, d, t0, n0;
    integer seed = 85;
    logic irq_prev = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] rdata, e, m;
    logic [7:0] c, r, v;
    logic [1:0] prev;
    logic osc_v[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic xtal_v[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic [1:0] src_v[4] = '{2'h2, 2'h2, 2'h1, 2'h0};
    logic [2:0] tap_v[4] = '{3'h0, 3'h1, 3'h0, 3'h0};
    logic [7:0] rl_v[4] = '{8'h00, 8'h00, 8'h02, 8'h00};

    always #20 ref_clk = ~ref_clk;

    wdtc_core DUT (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .power_down(power_down),
        .xtal_tick(xtal_tick),
        .wdt_irq(wdt_irq),
        .wake_req(wake_req),
        .chip_rst_req(chip_rst_req)
    );

    // ======================================================================
    // Tasks
    task automatic check(input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, ex, got);
        end
    endtask : check

    task automatic print_verdict;
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // Reads note their expectation; the monitor compares at the ack edge
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [7:0] dt, input logic [31:0] ex,
                       input logic [31:0] mk);
        int n;
        n = 0;
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, dt};
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 20) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, 1'b1, wb_ack_o);
        end
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        bus(1'b1, a, dt, 32'h0, 32'hFFFFFFFF);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                      input logic [31:0] mk);
        bus(1'b0, a, 8'h00, ex, mk);
    endtask : rd

    task automatic feed;
        wr(`WDTC_FEED1_OFS, `WDTC_FEED1_VAL);
        wr(`WDTC_FEED2_OFS, `WDTC_FEED2_VAL);
    endtask : feed

    // Bounded wait for the next irq rise (sel 0) or wake pulse (sel 1)
    task automatic wait_cnt(input logic sel);
        int b;
        int n;
        b = sel ? wakes : irq_rises;
        n = 0;
        while ((sel ? wakes : irq_rises) == b && n < 10000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 10000) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, b + 1, b);
        end
    endtask : wait_cnt

    // ======================================================================
    // Monitor: crystal ticks, bus results, event counts, hang guard
    always @(posedge ref_clk) begin
        cycles++;
        xtal_tick <= (cycles % 5 == 0);
        if (wb_ack_o === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            check(e & m, wb_dat_o & m);
        end
        if (wdt_irq === 1'b1 && irq_prev !== 1'b1) begin
            irq_rises++;
            rise_t = cycles;
        end
        irq_prev = wdt_irq;
        if (wake_req === 1'b1) wakes++;
        if (chip_rst_req === 1'b1) rsts++;
        if (cycles == 40000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rl_v[3] = 8'($random(seed)) & 8'h03;
        @(posedge ref_clk);
        rd(`WDTC_CTRL_OFS, 32'hE5, 32'hFFFFFFFF);
        rd(`WDTC_RELOAD_OFS, 32'hFF, 32'hFFFFFFFF);
        rd(`WDTC_CLKCFG_OFS, 32'h0, 32'hFFFFFFFF);
        rd(`WDTC_FEED1_OFS, 32'h0, 32'hFFFFFFFF);
        rd(8'h20, 32'h0, 32'hFFFFFFFF);
        rd(`WDTC_STATUS_OFS, 32'h200, 32'h600);
        // Old source stays until a feed; 300 cycles covers two slow ticks
        prev = 2'h1;
        for (int i = 0; i < 4; i++) begin
            wr(`WDTC_CTRL_OFS, {7'h02, osc_v[i]});
            wr(`WDTC_CLKCFG_OFS, {3'h0, xtal_v[i], 4'h0});
            rd(`WDTC_STATUS_OFS, {21'h0, prev, 9'h0}, 32'h600);
            feed();
            repeat (300) @(posedge ref_clk);
            rd(`WDTC_STATUS_OFS, {21'h0, src_v[i], 9'h0}, 32'h600);
            prev = src_v[i];
        end
        // Peripheral tick is two ref_clk cycles; period measured rise to rise
        wr(`WDTC_CLKCFG_OFS, 8'h40);
        for (int i = 0; i < 4; i++) begin
            t = (1 << (5 + tap_v[i])) * (rl_v[i] + 1) + 1;
            c = {tap_v[i], 5'h04};
            wr(`WDTC_RELOAD_OFS, rl_v[i]);
            wr(`WDTC_CTRL_OFS, c);
            feed();
            wait_cnt(1'b0);
            wr(`WDTC_CTRL_OFS, c | 8'h02);
            rd(`WDTC_CTRL_OFS, 32'h02, 32'h02);
            wr(`WDTC_CTRL_OFS, c);
            wait_cnt(1'b0);
            t0 = rise_t;
            rd(`WDTC_STATUS_OFS, {24'h0, rl_v[i]}, 32'hFF);
            wr(`WDTC_CTRL_OFS, c);
            rd(`WDTC_CTRL_OFS, 32'h0, 32'h02);
            wait_cnt(1'b0);
            d = rise_t - t0;
            check(32'(2 * t), 32'((d >= 2 * t - 2 && d <= 2 * t) ? 2 * t : d));
        end
        wr(`WDTC_CLKCFG_OFS, 8'h00);
        wr(`WDTC_CTRL_OFS, c);
        n0 = irq_rises;
        repeat (600) @(posedge ref_clk);
        rd(`WDTC_CTRL_OFS, 32'h02, 32'h02);
        check(32'(n0), 32'(irq_rises));
        wr(`WDTC_CTRL_OFS, 8'hE4);
        n0 = rsts;
        wr(`WDTC_FEED1_OFS, 8'hA5);
        wr(`WDTC_RELOAD_OFS, 8'h10);
        wr(`WDTC_FEED2_OFS, 8'h5A);
        r = 8'($random(seed));
        wr(`WDTC_RELOAD_OFS, r);
        feed();
        rd(`WDTC_STATUS_OFS, {24'h0, r}, 32'hFF);
        wr(`WDTC_CLKCFG_OFS, 8'h01);
        feed();
        wr(`WDTC_FEED1_OFS, 8'hA5);
        wr(`WDTC_FEED2_OFS, 8'h5B);
        repeat (3) @(posedge ref_clk);
        check(32'(n0 + 1), 32'(rsts));
        wr(`WDTC_CLKCFG_OFS, 8'h00);
        wr(`WDTC_RELOAD_OFS, 8'h03);
        wr(`WDTC_CTRL_OFS, 8'h04);
        feed();
        n0 = wakes;
        power_down <= 1'b1;
        rd(`WDTC_STATUS_OFS, 32'h0, 32'h700);
        v = rdata[7:0];
        repeat (600) @(posedge ref_clk);
        rd(`WDTC_STATUS_OFS, {24'h0, v}, 32'hFF);
        check(32'(n0), 32'(wakes));
        power_down <= 1'b0;
        wr(`WDTC_CTRL_OFS, 8'h05);
        feed();
        repeat (300) @(posedge ref_clk);
        n0 = wakes;
        power_down <= 1'b1;
        wait_cnt(1'b1);
        check(32'(n0 + 1), 32'(wakes));
        power_down <= 1'b0;
        print_verdict();
    end
endmodule : wdtc_core_tb
